// ===== scs_debounce.sv
`timescale 1ns/100ps
module scs_debounce
	import scs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        step_i,
	input  wire logic        level_i,
	input  wire logic [15:0] limit_i,
	output logic             hit_o
);
	logic [15:0] cnt_reg;

	// The count saturates at the limit so a long fault cannot wrap it.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_reg <= RST_WORD;
			hit_o   <= 1'b0;
		end
		else if (step_i)
		begin
			if (!level_i)
			begin
				cnt_reg <= RST_WORD;
				hit_o   <= 1'b0;
			end
			else
			begin
				if (cnt_reg < limit_i)
					cnt_reg <= cnt_reg + 16'h0001;
				hit_o <= ({1'b0, cnt_reg} + 17'h00001) >= {1'b0, limit_i};
			end
		end
	end
endmodule

// ===== scs_host_model.sv
`timescale 1ns/100ps
module scs_host_model
	import scs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        rvalid_i,
	output logic      [7:0]  addr_o,
	output logic      [7:0]  wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// After a request the address is inverted, and after a write the data too, so a design that
	// samples them without a strobe sees garbage rather than a stale value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		int n;
		@(posedge clk_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		rd_o = 1'b0;
		addr_o = ~a;
		n = 0;
		while (rvalid_i !== 1'b1 && n < 4)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
	endtask
endmodule

// ===== scs_pkg.sv
package scs_pkg;

	localparam int CLK_MHZ = 200;

	// Register offsets.
	localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_OCP_FLAG_CFG  = 8'h08;
	localparam logic [7:0] ADDR_EXT_FLAG_CFG  = 8'h0a;
	localparam logic [7:0] ADDR_ACC_OCP_DEB   = 8'h0e;
	localparam logic [7:0] ADDR_LOCAL_V       = 8'h15;
	localparam logic [7:0] ADDR_REMOTE_V      = 8'h17;
	localparam logic [7:0] ADDR_OUT_CURRENT   = 8'h18;
	localparam logic [7:0] ADDR_PRI_TRIM      = 8'h21;
	localparam logic [7:0] ADDR_OCP_LIMITS    = 8'h22;
	localparam logic [7:0] ADDR_CS_CFG        = 8'h27;
	localparam logic [7:0] ADDR_VSB_CFG       = 8'h28;
	localparam logic [7:0] ADDR_SUPPLY_ON     = 8'h2c;
	localparam logic [7:0] ADDR_PIN_POL       = 8'h2d;
	localparam logic [7:0] ADDR_TOPOLOGY      = 8'h40;
	localparam logic [7:0] ADDR_PWM1_EDGE     = 8'h42;
	localparam logic [7:0] ADDR_PWM2_EDGE     = 8'h46;
	localparam logic [7:0] ADDR_PWM3_EDGE     = 8'h4a;
	localparam logic [7:0] ADDR_PWM4_EDGE     = 8'h4e;
	localparam logic [7:0] ADDR_LINE_TRIM     = 8'h5e;
	localparam logic [7:0] ADDR_FF_CFG        = 8'h75;
	localparam logic [7:0] ADDR_FILTER_LATCH  = 8'h7f;

	// Field positions.
	localparam int BIT_SUPPLY_ON    = 5;
	localparam int BIT_STAT_OFF     = 7;
	localparam int BIT_STAT_ORING   = 6;
	localparam int BIT_STAT_SR      = 3;
	localparam int BIT_SENSE_HIGH   = 2;
	localparam int BIT_EXT_ROUTE    = 4;
	localparam int BIT_EXT_POL      = 2;
	localparam int BIT_FF_EN        = 2;
	localparam int BIT_FILTER_LATCH = 3;
	localparam int BIT_VSB_EN       = 6;
	localparam int BIT_VSB_LEB      = 5;
	localparam int BIT_VSB_HALF     = 3;
	localparam int MEAS_LSB         = 4;

	// Values after reset.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Timing steps, figures in ns, converted to clock cycles.
	localparam int BLANK_STEP_NS   = 40;
	localparam int FAST_DEB_NS     = 20;
	localparam int ACC_DEB_NS      = 100;
	localparam int LEB_NS          = 50;
	localparam int BLANK_STEP_CYC  = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int FAST_DEB_CYC    = (FAST_DEB_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_DEB_CYC     = (ACC_DEB_NS * CLK_MHZ + 999) / 1000;
	localparam int LEB_CYC         = (LEB_NS * CLK_MHZ + 999) / 1000;

	// Selection code times step size, used by every programmable delay.
	function automatic logic [15:0] scs_code_cycles(input logic [2:0] code,
		input int step);
		scs_code_cycles = 16'(int'(code) * step);
	endfunction

endpackage

// ===== scs_regs.sv
// Operation
// - Bit five of on register switches supply.
// - Report local voltage sample, bits fifteen-four.
// - Report remote differential voltage, bits fifteen-four.
// - Report output current sense drop, bits fifteen-four.
// - Supply off disables PWM, sets sticky status.
// - Rectifier disabled status from three causes.
// - Status bit six shows fast switch disabled.
// - Topology change moves all PWM frequencies.
// - Sense location selects high or low side.
// - Feed-forward gain; loop enabled by bit two.
// - Latch bit applies pending filter settings together.
// - External flag polarity selected by bit two.
// - Route external flag to fast comparator or pin.
// - Fast overcurrent blanking and debounce selected.
// - Fast flag after consecutive tripped switching cycles.
// - Accurate overcurrent threshold compare with debounce.
// - Each fault has timing bit and action.
// - Volt-second balance enable and gain.
// - Per-output rising edge starts balance integration.
// - Leading-edge blanking on selected rising edges.
// - Limit current sampling below half cycle.
// - Apply primary and line gain trims.
`timescale 1ns/100ps
module scs_regs
	import scs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	input  wire logic        meas_valid_i,
	input  wire logic [11:0] local_v_i,
	input  wire logic [11:0] remote_v_i,
	input  wire logic [11:0] out_current_i,
	input  wire logic        supply_fault_off_i,
	input  wire logic        sr_user_disable_i,
	input  wire logic        light_load_i,
	input  wire logic        flag_sr_disable_i,
	input  wire logic        oring_fast_dis_i,
	input  wire logic        ext_flag_pin_i,
	input  wire logic        fast_ocp_cmp_i,
	input  wire logic [4:0]  pri_current_i,
	input  wire logic        switch_cycle_start_i,
	input  wire logic [3:0]  pwm_rise_i,
	output logic             supply_on_o,
	output logic             pwm_enable_o,
	output logic      [5:0]  topology_o,
	output logic             freq_update_o,
	output logic             sense_high_side_o,
	output logic      [1:0]  ff_gain_o,
	output logic             ff_enable_o,
	output logic             filter_latch_o,
	output logic             ext_to_fast_ocp_o,
	output logic             ext_flag_o,
	output logic             fast_ocp_flag_o,
	output logic             acc_ocp_flag_o,
	output logic      [3:0]  ext_flag_cfg_o,
	output logic      [3:0]  fast_ocp_cfg_o,
	output logic      [3:0]  acc_ocp_cfg_o,
	output logic             vsb_enable_o,
	output logic      [1:0]  vsb_gain_o,
	output logic             vsb_start_o,
	output logic             cs_blank_o,
	output logic             cs_sample_ok_o,
	output logic      [7:0]  pri_gain_trim_o,
	output logic      [7:0]  line_gain_trim_o
);
	logic [7:0]  ocp_flag_cfg_reg;
	logic [7:0]  ext_flag_cfg_reg;
	logic [7:0]  acc_deb_reg;
	logic [15:0] local_v_reg;
	logic [15:0] remote_v_reg;
	logic [15:0] out_cur_reg;
	logic [7:0]  pri_trim_reg;
	logic [7:0]  ocp_limits_reg;
	logic [7:0]  cs_cfg_reg;
	logic [7:0]  vsb_cfg_reg;
	logic [7:0]  supply_reg;
	logic [7:0]  pin_pol_reg;
	logic [7:0]  line_trim_reg;
	logic [7:0]  ff_pend_reg;
	logic [7:0]  edge_reg [4];
	logic        off_flag_reg;
	logic        oring_flag_reg;
	logic        sr_flag_reg;
	logic        supply_on_prev_reg;
	logic        wr_hit_status;
	logic        wr_topology;
	logic        wr_latch;
	logic [3:0]  edge_sel;
	logic [15:0] blank_reg;
	logic        fast_trip;
	logic        fast_deb_hit;
	logic        trip_seen_reg;
	logic        ext_active;
	logic [15:0] rd_next;

	function automatic logic wr_at(input logic [7:0] addr);
		wr_at = reg_wr_i && reg_addr_i == addr;
	endfunction

	// The decode reads the strobe inside the function, so it lives in a
	// process that also wakes on what the function reads.
	always_comb
	begin
		wr_hit_status = wr_at(ADDR_FAULT_STATUS);
		wr_topology   = wr_at(ADDR_TOPOLOGY);
		wr_latch      = wr_at(ADDR_FILTER_LATCH) &&
			reg_wdata_i[BIT_FILTER_LATCH];
	end
	assign ext_active    = ext_flag_pin_i ^ pin_pol_reg[BIT_EXT_POL];

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ocp_flag_cfg_reg <= RST_BYTE;
			ext_flag_cfg_reg <= RST_BYTE;
			acc_deb_reg      <= RST_BYTE;
			pri_trim_reg     <= RST_BYTE;
			ocp_limits_reg   <= RST_BYTE;
			cs_cfg_reg       <= RST_BYTE;
			vsb_cfg_reg      <= RST_BYTE;
			supply_reg       <= RST_BYTE;
			pin_pol_reg      <= RST_BYTE;
			line_trim_reg    <= RST_BYTE;
			ff_pend_reg      <= RST_BYTE;
			for (int i = 0; i < 4; i++)
				edge_reg[i] <= RST_BYTE;
		end
		else if (reg_wr_i)
		begin
			// Read-only offsets fall through untouched.
			unique case (reg_addr_i)
				ADDR_OCP_FLAG_CFG: ocp_flag_cfg_reg <= reg_wdata_i;
				ADDR_EXT_FLAG_CFG: ext_flag_cfg_reg <= reg_wdata_i;
				ADDR_ACC_OCP_DEB:  acc_deb_reg      <= reg_wdata_i;
				ADDR_PRI_TRIM:     pri_trim_reg     <= reg_wdata_i;
				ADDR_OCP_LIMITS:   ocp_limits_reg   <= reg_wdata_i;
				ADDR_CS_CFG:       cs_cfg_reg       <= reg_wdata_i;
				ADDR_VSB_CFG:      vsb_cfg_reg      <= reg_wdata_i;
				ADDR_SUPPLY_ON:    supply_reg       <= reg_wdata_i;
				ADDR_PIN_POL:      pin_pol_reg      <= reg_wdata_i;
				ADDR_LINE_TRIM:    line_trim_reg    <= reg_wdata_i;
				ADDR_FF_CFG:       ff_pend_reg      <= reg_wdata_i;
				ADDR_PWM1_EDGE:    edge_reg[0]      <= reg_wdata_i;
				ADDR_PWM2_EDGE:    edge_reg[1]      <= reg_wdata_i;
				ADDR_PWM3_EDGE:    edge_reg[2]      <= reg_wdata_i;
				ADDR_PWM4_EDGE:    edge_reg[3]      <= reg_wdata_i;
				default:           ;
			endcase
		end
	end

	// Whole words are loaded on one edge, so a read never sees a torn value.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			local_v_reg  <= RST_WORD;
			remote_v_reg <= RST_WORD;
			out_cur_reg  <= RST_WORD;
		end
		else if (meas_valid_i)
		begin
			local_v_reg  <= {local_v_i, 4'h0};
			remote_v_reg <= {remote_v_i, 4'h0};
			out_cur_reg  <= {out_current_i, 4'h0};
		end
	end

	// Off flag is sticky until the supply bit is raised again.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			supply_on_prev_reg <= 1'b0;
			off_flag_reg       <= 1'b1;
			oring_flag_reg     <= 1'b0;
			sr_flag_reg        <= 1'b0;
			supply_on_o        <= 1'b0;
			pwm_enable_o       <= 1'b0;
		end
		else
		begin
			supply_on_prev_reg <= supply_reg[BIT_SUPPLY_ON];
			supply_on_o        <= supply_reg[BIT_SUPPLY_ON];
			pwm_enable_o       <= supply_reg[BIT_SUPPLY_ON] &&
				!supply_fault_off_i && !off_flag_reg;
			if (!supply_reg[BIT_SUPPLY_ON] || supply_fault_off_i)
				off_flag_reg <= 1'b1;
			else if (!supply_on_prev_reg)
				off_flag_reg <= 1'b0;
			// Hardware set wins over a host write in the same cycle.
			if (oring_fast_dis_i)
				oring_flag_reg <= 1'b1;
			else if (wr_hit_status)
				oring_flag_reg <= reg_wdata_i[BIT_STAT_ORING];
			sr_flag_reg <= sr_user_disable_i || light_load_i ||
				flag_sr_disable_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			topology_o    <= 6'h00;
			freq_update_o <= 1'b0;
		end
		else
		begin
			freq_update_o <= wr_topology && reg_wdata_i[5:0] != topology_o;
			if (wr_topology)
				topology_o <= reg_wdata_i[5:0];
		end
	end

	// Filter settings take effect only on the latch strobe.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ff_gain_o      <= 2'h0;
			ff_enable_o    <= 1'b0;
			filter_latch_o <= 1'b0;
		end
		else
		begin
			filter_latch_o <= wr_latch;
			if (wr_latch)
			begin
				ff_gain_o   <= ff_pend_reg[1:0];
				ff_enable_o <= ff_pend_reg[BIT_FF_EN];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sense_high_side_o <= 1'b0;
			ext_to_fast_ocp_o <= 1'b0;
			ext_flag_o        <= 1'b0;
			ext_flag_cfg_o    <= 4'h0;
			fast_ocp_cfg_o    <= 4'h0;
			acc_ocp_cfg_o     <= 4'h0;
			vsb_enable_o      <= 1'b0;
			vsb_gain_o        <= 2'h0;
			pri_gain_trim_o   <= RST_BYTE;
			line_gain_trim_o  <= RST_BYTE;
		end
		else
		begin
			sense_high_side_o <= cs_cfg_reg[BIT_SENSE_HIGH];
			ext_to_fast_ocp_o <= cs_cfg_reg[BIT_EXT_ROUTE];
			ext_flag_o        <= !cs_cfg_reg[BIT_EXT_ROUTE] && ext_active;
			ext_flag_cfg_o    <= ext_flag_cfg_reg[3:0];
			fast_ocp_cfg_o    <= ocp_flag_cfg_reg[7:4];
			acc_ocp_cfg_o     <= ocp_flag_cfg_reg[3:0];
			vsb_enable_o      <= vsb_cfg_reg[BIT_VSB_EN];
			vsb_gain_o        <= vsb_cfg_reg[1:0];
			pri_gain_trim_o   <= pri_trim_reg;
			line_gain_trim_o  <= line_trim_reg;
		end
	end

	// Blanking restarts on each switching cycle; comparator is ignored then.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			blank_reg <= RST_WORD;
		else if (switch_cycle_start_i)
			blank_reg <= scs_code_cycles(ocp_limits_reg[7:5], BLANK_STEP_CYC);
		else if (blank_reg != RST_WORD)
			blank_reg <= blank_reg - 16'h0001;
	end

	assign fast_trip = blank_reg == RST_WORD && !switch_cycle_start_i &&
		(fast_ocp_cmp_i || (cs_cfg_reg[BIT_EXT_ROUTE] && ext_active));

	scs_debounce u_fast_deb (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.step_i  (1'b1),
		.level_i (fast_trip),
		.limit_i (scs_code_cycles({1'b0, cs_cfg_reg[7:6]}, FAST_DEB_CYC)),
		.hit_o   (fast_deb_hit)
	);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			trip_seen_reg <= 1'b0;
		else if (switch_cycle_start_i)
			trip_seen_reg <= 1'b0;
		else if (fast_deb_hit)
			trip_seen_reg <= 1'b1;
	end

	scs_debounce u_fast_cycles (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.step_i  (switch_cycle_start_i),
		.level_i (trip_seen_reg),
		.limit_i ({14'h0000, cs_cfg_reg[1:0]} + 16'h0001),
		.hit_o   (fast_ocp_flag_o)
	);

	scs_debounce u_acc_deb (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.step_i  (1'b1),
		.level_i (pri_current_i >= ocp_limits_reg[4:0]),
		.limit_i (scs_code_cycles(acc_deb_reg[4:2], ACC_DEB_CYC)),
		.hit_o   (acc_ocp_flag_o)
	);

	assign edge_sel = {edge_reg[3][0], edge_reg[2][0], edge_reg[1][0],
		edge_reg[0][0]};

	scs_vsb_window u_vsb (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n_i),
		.pwm_rise_i    (pwm_rise_i),
		.edge_sel_i    (edge_sel),
		.vsb_en_i      (vsb_cfg_reg[BIT_VSB_EN]),
		.leb_en_i      (vsb_cfg_reg[BIT_VSB_LEB]),
		.half_limit_i  (vsb_cfg_reg[BIT_VSB_HALF]),
		.integ_start_o (vsb_start_o),
		.cs_blank_o    (cs_blank_o),
		.sample_ok_o   (cs_sample_ok_o)
	);

	always_comb
	begin
		rd_next = RST_WORD;
		unique case (reg_addr_i)
			ADDR_FAULT_STATUS: rd_next = {8'h00, off_flag_reg, oring_flag_reg,
				2'b00, sr_flag_reg, 3'b000};
			ADDR_OCP_FLAG_CFG: rd_next = {8'h00, ocp_flag_cfg_reg};
			ADDR_EXT_FLAG_CFG: rd_next = {8'h00, ext_flag_cfg_reg};
			ADDR_ACC_OCP_DEB:  rd_next = {8'h00, acc_deb_reg};
			ADDR_LOCAL_V:      rd_next = local_v_reg;
			ADDR_REMOTE_V:     rd_next = remote_v_reg;
			ADDR_OUT_CURRENT:  rd_next = out_cur_reg;
			ADDR_PRI_TRIM:     rd_next = {8'h00, pri_trim_reg};
			ADDR_OCP_LIMITS:   rd_next = {8'h00, ocp_limits_reg};
			ADDR_CS_CFG:       rd_next = {8'h00, cs_cfg_reg};
			ADDR_VSB_CFG:      rd_next = {8'h00, vsb_cfg_reg};
			ADDR_SUPPLY_ON:    rd_next = {8'h00, supply_reg};
			ADDR_PIN_POL:      rd_next = {8'h00, pin_pol_reg};
			ADDR_TOPOLOGY:     rd_next = {10'h000, topology_o};
			ADDR_PWM1_EDGE:    rd_next = {8'h00, edge_reg[0]};
			ADDR_PWM2_EDGE:    rd_next = {8'h00, edge_reg[1]};
			ADDR_PWM3_EDGE:    rd_next = {8'h00, edge_reg[2]};
			ADDR_PWM4_EDGE:    rd_next = {8'h00, edge_reg[3]};
			ADDR_LINE_TRIM:    rd_next = {8'h00, line_trim_reg};
			ADDR_FF_CFG:       rd_next = {8'h00, ff_pend_reg};
			default:           rd_next = RST_WORD;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o  <= RST_WORD;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= rd_next;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_supply_follows_bit: assert property (
		wr_at(ADDR_SUPPLY_ON) |=> ##1
			supply_on_o == $past(reg_wdata_i[BIT_SUPPLY_ON], 2))
		else $error("supply output does not follow its control bit");
	a_meas_capture: assert property (
		meas_valid_i ##1 !meas_valid_i ##1
			reg_rd_i && reg_addr_i == ADDR_LOCAL_V |=>
			reg_rdata_o == {$past(local_v_i, 3), 4'h0})
		else $error("local voltage reading wrong");
	a_ro_write_ignored: assert property (
		wr_at(ADDR_LOCAL_V) && !meas_valid_i |=> $stable(local_v_reg))
		else $error("write changed a read-only measurement");
	a_off_pwm_disabled: assert property (
		!supply_reg[BIT_SUPPLY_ON] |=> !pwm_enable_o && off_flag_reg)
		else $error("PWM left enabled while supply off");
	a_sr_status: assert property (
		light_load_i |=> reg_rd_i && reg_addr_i == ADDR_FAULT_STATUS
			|=> reg_rdata_o[BIT_STAT_SR])
		else $error("rectifier status missing");
	a_topology_pulse: assert property (
		wr_topology && reg_wdata_i[5:0] != topology_o |=>
			freq_update_o && topology_o == $past(reg_wdata_i[5:0]))
		else $error("topology change not applied");
	a_latch_ff: assert property (
		wr_latch |=> ff_enable_o == $past(ff_pend_reg[BIT_FF_EN]) &&
			filter_latch_o)
		else $error("feed-forward latch failed");
	a_ext_polarity: assert property (
		!cs_cfg_reg[BIT_EXT_ROUTE] && $stable(cs_cfg_reg) |=>
			ext_flag_o == $past(ext_flag_pin_i ^ pin_pol_reg[BIT_EXT_POL]))
		else $error("external flag polarity wrong");
	a_rd_unmapped: assert property (
		reg_rd_i && reg_addr_i == 8'h01 |=> reg_rvalid_o && reg_rdata_o == 16'h0)
		else $error("unmapped read not zero");

	c_freq_update: cover property (freq_update_o);
	c_fast_ocp: cover property (!fast_ocp_flag_o ##1 fast_ocp_flag_o);
	c_filter_latch: cover property (filter_latch_o ##1 ff_enable_o);
endmodule

// ===== scs_vsb_window.sv
`timescale 1ns/100ps
module scs_vsb_window
	import scs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] pwm_rise_i,
	input  wire logic [3:0] edge_sel_i,
	input  wire logic       vsb_en_i,
	input  wire logic       leb_en_i,
	input  wire logic       half_limit_i,
	output logic            integ_start_o,
	output logic            cs_blank_o,
	output logic            sample_ok_o
);
	logic [15:0] phase_reg;
	logic [15:0] last_len_reg;
	logic [15:0] leb_reg;
	logic        any_rise;
	logic        sel_rise;

	assign any_rise = |pwm_rise_i;
	assign sel_rise = vsb_en_i && |(pwm_rise_i & edge_sel_i);

	// Half-cycle length is half the interval between the last two rising edges on any output.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_reg    <= RST_WORD;
			last_len_reg <= RST_WORD;
		end
		else if (any_rise)
		begin
			phase_reg    <= RST_WORD;
			last_len_reg <= phase_reg;
		end
		else if (phase_reg != 16'hffff)
			phase_reg <= phase_reg + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			leb_reg       <= RST_WORD;
			integ_start_o <= 1'b0;
			cs_blank_o    <= 1'b0;
			sample_ok_o   <= 1'b1;
		end
		else
		begin
			integ_start_o <= sel_rise;
			if (sel_rise && leb_en_i)
				leb_reg <= 16'(LEB_CYC);
			else if (leb_reg != RST_WORD)
				leb_reg <= leb_reg - 16'h0001;
			cs_blank_o  <= (sel_rise && leb_en_i) || leb_reg > 16'h0001;
			sample_ok_o <= !half_limit_i || any_rise ||
				(phase_reg + 16'h0001) < {1'b0, last_len_reg[15:1]};
		end
	end
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
	import scs_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  reg_addr_i, reg_wdata_i;
	logic        reg_wr_i, reg_rd_i, meas_valid_i, supply_fault_off_i;
	logic        sr_user_disable_i, light_load_i, flag_sr_disable_i;
	logic        oring_fast_dis_i, ext_flag_pin_i, fast_ocp_cmp_i;
	logic        switch_cycle_start_i;
	logic [11:0] local_v_i, remote_v_i, out_current_i;
	logic [4:0]  pri_current_i;
	logic [3:0]  pwm_rise_i;
	logic [15:0] reg_rdata_o;
	logic        reg_rvalid_o, supply_on_o, pwm_enable_o, freq_update_o;
	logic        sense_high_side_o, ff_enable_o, filter_latch_o;
	logic        ext_to_fast_ocp_o, ext_flag_o, fast_ocp_flag_o;
	logic        acc_ocp_flag_o, vsb_enable_o, vsb_start_o;
	logic        cs_blank_o, cs_sample_ok_o;
	logic [5:0]  topology_o;
	logic [1:0]  ff_gain_o, vsb_gain_o;
	logic [3:0]  ext_flag_cfg_o, fast_ocp_cfg_o, acc_ocp_cfg_o;
	logic [7:0]  pri_gain_trim_o, line_gain_trim_o;
	logic [15:0] rv;
	logic        a_lvl;
	int          errors = 0;
	int          n_checks = 0;
	int          k, nb, ns;
	localparam logic [7:0] TA [13] = '{8'h08, 8'h0a, 8'h0e, 8'h21, 8'h22,
		8'h27, 8'h28, 8'h2d, 8'h40, 8'h42, 8'h46, 8'h4a, 8'h4e};
	localparam logic [7:0] TD [13] = '{8'hff, 8'h0b, 8'h1c, 8'ha5, 8'hff,
		8'hd7, 8'h6b, 8'h04, 8'h2a, 8'h01, 8'h00, 8'h01, 8'h01};

	always #2.5 clk_i = ~clk_i;

	scs_regs dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .meas_valid_i, .local_v_i,
		.remote_v_i, .out_current_i, .supply_fault_off_i, .sr_user_disable_i,
		.light_load_i, .flag_sr_disable_i, .oring_fast_dis_i, .ext_flag_pin_i,
		.fast_ocp_cmp_i, .pri_current_i, .switch_cycle_start_i, .pwm_rise_i,
		.supply_on_o, .pwm_enable_o, .topology_o, .freq_update_o,
		.sense_high_side_o, .ff_gain_o, .ff_enable_o, .filter_latch_o,
		.ext_to_fast_ocp_o, .ext_flag_o, .fast_ocp_flag_o, .acc_ocp_flag_o,
		.ext_flag_cfg_o, .fast_ocp_cfg_o, .acc_ocp_cfg_o, .vsb_enable_o,
		.vsb_gain_o, .vsb_start_o, .cs_blank_o, .cs_sample_ok_o,
		.pri_gain_trim_o, .line_gain_trim_o);

	scs_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
		.rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
		.wr_o(reg_wr_i), .rd_o(reg_rd_i));

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [15:0] exp);
		host.rd(a, rv);
		check(nm, rv, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Pulse outputs are counted over a window, not sampled at one edge,
	// so the exact registering latency does not decide the outcome.
	task automatic cnt(ref logic s, input int n, output int c);
		c = 0;
		repeat (n)
		begin
			c += (s === 1'b1);
			cyc(1);
		end
	endtask

	task automatic rise(input logic [3:0] p);
		pwm_rise_i = p;
		cyc(1);
		pwm_rise_i = 4'h0;
		nb = 0;
		ns = 0;
		repeat (16)
		begin
			nb += (cs_blank_o === 1'b1);
			ns += (vsb_start_o === 1'b1);
			cyc(1);
		end
	endtask

	task automatic wrap_up;
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		errors++;
		wrap_up();
	end

	initial
	begin
		{meas_valid_i, supply_fault_off_i, sr_user_disable_i} = 3'h0;
		{light_load_i, flag_sr_disable_i, oring_fast_dis_i} = 3'h0;
		{ext_flag_pin_i, fast_ocp_cmp_i, switch_cycle_start_i} = 3'h0;
		{local_v_i, remote_v_i, out_current_i} = 36'h0;
		pri_current_i = 5'h00;
		pwm_rise_i = 4'h0;
		repeat (4) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		rchk("status at reset", ADDR_FAULT_STATUS, 16'h0080);
		rchk("unmapped read", 8'h01, 16'h0000);
		host.wr(ADDR_SUPPLY_ON, 8'h20);
		cyc(3);
		check("supply_on_o", supply_on_o, 16'h0001);
		check("pwm_enable_o", pwm_enable_o, 16'h0001);
		rchk("status after restart", ADDR_FAULT_STATUS, 16'h0000);
		host.wr(ADDR_FAULT_STATUS, 8'h80);
		rchk("status ro bit", ADDR_FAULT_STATUS, 16'h0000);
		for (k = 0; k < 3; k++)
		begin
			{sr_user_disable_i, light_load_i, flag_sr_disable_i} = 3'h1 << k;
			cyc(2);
			rchk("rectifier status", ADDR_FAULT_STATUS, 16'h0008);
		end
		{sr_user_disable_i, light_load_i, flag_sr_disable_i} = 3'h0;
		oring_fast_dis_i = 1'b1;
		cyc(1);
		oring_fast_dis_i = 1'b0;
		cyc(2);
		rchk("oring status", ADDR_FAULT_STATUS, 16'h0040);
		host.wr(ADDR_FAULT_STATUS, 8'h00);
		rchk("oring cleared", ADDR_FAULT_STATUS, 16'h0000);
		supply_fault_off_i = 1'b1;
		cyc(2);
		check("pwm off on fault", pwm_enable_o, 16'h0000);
		supply_fault_off_i = 1'b0;
		cyc(2);
		rchk("off flag sticky", ADDR_FAULT_STATUS, 16'h0080);
		{local_v_i, remote_v_i, out_current_i} = 36'habc123fed;
		meas_valid_i = 1'b1;
		cyc(1);
		meas_valid_i = 1'b0;
		{local_v_i, remote_v_i, out_current_i} = 36'h0;
		rchk("local voltage", ADDR_LOCAL_V, 16'habc0);
		rchk("remote voltage", ADDR_REMOTE_V, 16'h1230);
		rchk("output current", ADDR_OUT_CURRENT, 16'hfed0);
		host.wr(ADDR_LOCAL_V, 8'h00);
		rchk("local voltage ro", ADDR_LOCAL_V, 16'habc0);
		host.wr(ADDR_SUPPLY_ON, 8'h00);
		cyc(3);
		check("supply off", supply_on_o, 16'h0000);
		check("pwm off", pwm_enable_o, 16'h0000);
		rchk("status off", ADDR_FAULT_STATUS, 16'h0080);
		for (k = 0; k < 13; k++)
		begin
			host.wr(TA[k], TD[k]);
			rchk("config readback", TA[k], {8'h00, TD[k]});
		end
		cyc(2);
		check("sense_high_side_o", sense_high_side_o, 16'h1);
		check("ext_to_fast_ocp_o", ext_to_fast_ocp_o, 16'h1);
		check("vsb_enable_o", vsb_enable_o, 16'h1);
		check("vsb_gain_o", vsb_gain_o, 16'h3);
		check("pri_gain_trim_o", pri_gain_trim_o, 16'ha5);
		check("ext_flag_cfg_o", ext_flag_cfg_o, 16'hb);
		check("fast_ocp_cfg_o", fast_ocp_cfg_o, 16'hf);
		check("acc_ocp_cfg_o", acc_ocp_cfg_o, 16'hf);
		check("topology_o", topology_o, 16'h2a);
		host.wr(ADDR_LINE_TRIM, 8'h5a);
		cyc(2);
		check("line_gain_trim_o", line_gain_trim_o, 16'h5a);
		rise(4'h2);
		check("blank on unselected edge", 16'(nb), 16'h0);
		check("sampling open", cs_sample_ok_o, 16'h0001);
		rise(4'h1);
		check("blank length", 16'(nb), 16'(LEB_CYC));
		check("integration starts", 16'(ns), 16'h1);
		check("sampling closed late", cs_sample_ok_o, 16'h0000);
		host.wr(ADDR_TOPOLOGY, 8'h15);
		cnt(freq_update_o, 4, k);
		check("freq update on change", 16'(k), 16'h1);
		host.wr(ADDR_TOPOLOGY, 8'h15);
		cnt(freq_update_o, 4, k);
		check("freq update on same", 16'(k), 16'h0);
		host.wr(ADDR_FF_CFG, 8'h07);
		cyc(3);
		check("ff pending", ff_enable_o, 16'h0);
		host.wr(ADDR_FILTER_LATCH, 8'h08);
		cnt(filter_latch_o, 4, k);
		check("latch pulses", 16'(k), 16'h1);
		check("ff_gain_o", ff_gain_o, 16'h3);
		check("ff_enable_o", ff_enable_o, 16'h1);
		rchk("latch reads zero", ADDR_FILTER_LATCH, 16'h0000);
		host.wr(ADDR_CS_CFG, 8'h00);
		host.wr(ADDR_PIN_POL, 8'h00);
		ext_flag_pin_i = 1'b1;
		cyc(3);
		a_lvl = ext_flag_o;
		host.wr(ADDR_PIN_POL, 8'h04);
		cyc(3);
		check("ext flag polarity", {15'h0, ext_flag_o ^ a_lvl}, 16'h1);
		check("ext route pin", ext_to_fast_ocp_o, 16'h0);
		ext_flag_pin_i = 1'b0;
		host.wr(ADDR_OCP_LIMITS, 8'h10);
		host.wr(ADDR_ACC_OCP_DEB, 8'h04);
		pri_current_i = 5'h10;
		cyc(10);
		check("acc ocp early", acc_ocp_flag_o, 16'h0);
		cyc(20);
		check("acc ocp set", acc_ocp_flag_o, 16'h1);
		pri_current_i = 5'h0f;
		cyc(3);
		check("acc ocp below limit", acc_ocp_flag_o, 16'h0);
		fast_ocp_cmp_i = 1'b1;
		cyc(4);
		check("fast ocp before cycle", fast_ocp_flag_o, 16'h0);
		repeat (2)
		begin
			switch_cycle_start_i = 1'b1;
			cyc(1);
			switch_cycle_start_i = 1'b0;
			cyc(4);
		end
		check("fast ocp set", fast_ocp_flag_o, 16'h1);
		wrap_up();
	end
endmodule
